//--- ccm_pkg.sv
// constants, register map and mode type shared by the compare/capture module files
package ccm_pkg;

	// bus and counter widths
	localparam int DATA_W = 8;
	localparam int ADDR_W = 3;
	localparam int COUNT_W = 16;

	// register offsets, one byte register per address
	localparam logic [ADDR_W-1:0] ADDR_CONTROL_STATUS = 3'h0;
	localparam logic [ADDR_W-1:0] ADDR_MODE_CONTROL   = 3'h1;
	localparam logic [ADDR_W-1:0] ADDR_COUNT_LOW      = 3'h2;
	localparam logic [ADDR_W-1:0] ADDR_COUNT_HIGH     = 3'h3;
	localparam logic [ADDR_W-1:0] ADDR_VALUE_LOW      = 3'h4;
	localparam logic [ADDR_W-1:0] ADDR_VALUE_HIGH     = 3'h5;

	// module_mode_control field positions
	localparam int BIT_COMPARATOR_ENABLE  = 6;
	localparam int BIT_RISING_CAPTURE     = 5;
	localparam int BIT_FALLING_CAPTURE    = 4;
	localparam int BIT_MATCH_FLAG_ENABLE  = 3;
	localparam int BIT_MATCH_TOGGLE       = 2;
	localparam int BIT_PULSE_WIDTH        = 1;
	localparam int BIT_MODULE_IRQ_ENABLE  = 0;

	// array_control_status field positions
	localparam int BIT_COUNTER_OVERFLOW   = 7;
	localparam int BIT_COUNTER_RUN        = 6;
	localparam int BIT_MODULE_EVENT_FLAG  = 0;

	// implemented bits, the rest read as zero
	localparam logic [DATA_W-1:0] MODE_IMPL_MASK    = 8'h7f;
	localparam logic [DATA_W-1:0] CONTROL_IMPL_MASK = 8'hc1;

	// reset values, counter limits and counter step
	localparam logic [DATA_W-1:0]  MODE_RESET    = 8'h00;
	localparam logic [COUNT_W-1:0] COUNT_RESET   = 16'h0000;
	localparam logic [COUNT_W-1:0] VALUE_RESET   = 16'h0000;
	localparam logic [DATA_W-1:0]  READ_IDLE     = 8'h00;
	localparam logic               PIN_RESET     = 1'b1;
	localparam logic [DATA_W-1:0]  LOW_BYTE_TOP  = 8'hff;
	localparam logic [COUNT_W-1:0] COUNT_TOP     = 16'hffff;
	localparam logic [COUNT_W-1:0] COUNT_STEP    = 16'h0001;

	// decoded module function
	typedef enum logic [2:0] {
		MODE_IDLE       = 3'b000,
		MODE_CAPTURE    = 3'b001,
		MODE_TIMER      = 3'b010,
		MODE_HIGH_SPEED = 3'b011,
		MODE_PWM        = 3'b100,
		MODE_OTHER      = 3'b101
	} mode_type;

endpackage

//--- pin_edge_if.sv
// interface between the pin edge detector and the module core
`timescale 1ns/1ps
interface pin_edge_if;
	logic raw_pin;
	logic rise_pulse;
	logic fall_pulse;

	modport detector (
		input  raw_pin,
		output rise_pulse,
		output fall_pulse
	);

	modport core (
		output raw_pin,
		input  rise_pulse,
		input  fall_pulse
	);
endinterface

//--- pin_edge_detect.sv
// two-stage synchroniser and edge detector for the module pin
`timescale 1ns/1ps
module pin_edge_detect (
	// clock and reset
	input  wire logic mclk_in,
	input  wire logic rst_n_in,
	// pin edge group
	pin_edge_if.detector edges
);

	logic meta_reg;
	logic sync_reg;
	logic last_reg;
	logic rise_reg;
	logic fall_reg;
	logic rise_next;
	logic fall_next;

	// edges are taken between the second and third stage only, never from the first
	assign rise_next = sync_reg & ~last_reg;
	assign fall_next = ~sync_reg & last_reg;

	// idle level high so a pin held high from reset gives no false edge
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			meta_reg <= ccm_pkg::PIN_RESET;
			sync_reg <= ccm_pkg::PIN_RESET;
			last_reg <= ccm_pkg::PIN_RESET;
			rise_reg <= 1'b0;
			fall_reg <= 1'b0;
		end else begin
			meta_reg <= edges.raw_pin;
			sync_reg <= meta_reg;
			last_reg <= sync_reg;
			rise_reg <= rise_next;
			fall_reg <= fall_next;
		end
	end

	assign edges.rise_pulse = rise_reg;
	assign edges.fall_pulse = fall_reg;

endmodule

//--- compare_capture_module.sv
// compare/capture module with its shared counter, register port and pin logic
//
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module compare_capture_module (
	// clock and reset
	input  wire logic                        mclk_in,
	input  wire logic                        rst_n_in,
	// register port
	input  wire logic [ccm_pkg::ADDR_W-1:0]  reg_addr_in,
	input  wire logic [ccm_pkg::DATA_W-1:0]  reg_wdata_in,
	input  wire logic                        reg_write_in,
	input  wire logic                        reg_read_in,
	output logic      [ccm_pkg::DATA_W-1:0]  reg_rdata_out,
	// module pin, two-way
	input  wire logic                        module_pin_in,
	output logic                             module_pin_out,
	output logic                             module_pin_oe_n_out,
	// interrupt request and status
	output logic                             module_irq_out,
	output logic [2:0]                       module_function_out
);

	// registers
	logic [ccm_pkg::DATA_W-1:0]  mode_reg;
	logic [ccm_pkg::COUNT_W-1:0] counter_reg;
	logic [ccm_pkg::COUNT_W-1:0] value_reg;
	logic                        counter_run_reg;
	logic                        overflow_flag_reg;
	logic                        event_flag_reg;
	logic                        advanced_reg;
	logic                        pin_level_reg;
	logic                        pin_oe_n_reg;
	logic                        irq_reg;
	logic [ccm_pkg::DATA_W-1:0]  rdata_reg;
	ccm_pkg::mode_type           function_reg;

	// next values
	logic [ccm_pkg::DATA_W-1:0]  mode_next;
	logic [ccm_pkg::COUNT_W-1:0] counter_next;
	logic [ccm_pkg::COUNT_W-1:0] value_next;
	logic                        counter_run_next;
	logic                        overflow_flag_next;
	logic                        event_flag_next;
	logic                        advanced_next;
	logic                        pin_level_next;
	logic                        pin_oe_n_next;
	logic                        irq_next;
	logic [ccm_pkg::DATA_W-1:0]  rdata_next;
	ccm_pkg::mode_type           function_next;

	// mode fields
	logic comparator_enable;
	logic rising_capture_enable;
	logic falling_capture_enable;
	logic match_flag_enable;
	logic match_toggle_enable;
	logic pulse_width_enable;
	logic module_irq_enable;

	// decoded functions
	logic capture_mode;
	logic timer_mode;
	logic high_speed_mode;
	logic pwm_mode;

	// events and counter steps
	logic capture_event;
	logic match_event;
	logic counter_advance;
	logic low_byte_wrap;
	logic full_wrap;

	// pin output control
	logic pwm_level;
	logic drive_pin;

	// address selects
	logic control_sel;
	logic mode_sel;
	logic count_low_sel;
	logic count_high_sel;
	logic value_low_sel;
	logic value_high_sel;

	// bus decode
	logic write_control;
	logic write_mode;
	logic write_count_low;
	logic write_count_high;
	logic write_value_low;
	logic write_value_high;
	logic count_written;
	logic [ccm_pkg::DATA_W-1:0] control_view;
	logic [ccm_pkg::DATA_W-1:0] read_value;

	// pin edge detection; two sync stages plus the edge stage put a capture
	// about three clocks behind the pin, so the captured count lags by that much
	pin_edge_if pin_edges ();

	assign pin_edges.raw_pin = module_pin_in;

	pin_edge_detect edge_unit (
		.mclk_in  (mclk_in),
		.rst_n_in (rst_n_in),
		.edges    (pin_edges)
	);

	// mode fields straight from the mode register
	assign comparator_enable      = mode_reg[ccm_pkg::BIT_COMPARATOR_ENABLE];
	assign rising_capture_enable  = mode_reg[ccm_pkg::BIT_RISING_CAPTURE];
	assign falling_capture_enable = mode_reg[ccm_pkg::BIT_FALLING_CAPTURE];
	assign match_flag_enable      = mode_reg[ccm_pkg::BIT_MATCH_FLAG_ENABLE];
	assign match_toggle_enable    = mode_reg[ccm_pkg::BIT_MATCH_TOGGLE];
	assign pulse_width_enable     = mode_reg[ccm_pkg::BIT_PULSE_WIDTH];
	assign module_irq_enable      = mode_reg[ccm_pkg::BIT_MODULE_IRQ_ENABLE];

	// function decode following the mode table
	assign capture_mode = (rising_capture_enable | falling_capture_enable) & ~match_flag_enable
		& ~match_toggle_enable & ~pulse_width_enable;
	assign timer_mode = comparator_enable & match_flag_enable & ~match_toggle_enable
		& ~pulse_width_enable & ~rising_capture_enable & ~falling_capture_enable;
	assign high_speed_mode = comparator_enable & match_flag_enable & match_toggle_enable
		& ~pulse_width_enable & ~rising_capture_enable & ~falling_capture_enable;
	assign pwm_mode = comparator_enable & pulse_width_enable & ~rising_capture_enable
		& ~falling_capture_enable & ~match_flag_enable & ~match_toggle_enable & ~module_irq_enable;

	// status code; the four settings exclude one another, so the chain order is free
	assign function_next = pwm_mode        ? ccm_pkg::MODE_PWM :
	                       high_speed_mode ? ccm_pkg::MODE_HIGH_SPEED :
	                       timer_mode      ? ccm_pkg::MODE_TIMER :
	                       capture_mode    ? ccm_pkg::MODE_CAPTURE :
	                       (mode_reg == ccm_pkg::MODE_RESET) ? ccm_pkg::MODE_IDLE : ccm_pkg::MODE_OTHER;

	// address selects; one compare per register, shared by the write and read decode
	assign control_sel    = (reg_addr_in == ccm_pkg::ADDR_CONTROL_STATUS);
	assign mode_sel       = (reg_addr_in == ccm_pkg::ADDR_MODE_CONTROL);
	assign count_low_sel  = (reg_addr_in == ccm_pkg::ADDR_COUNT_LOW);
	assign count_high_sel = (reg_addr_in == ccm_pkg::ADDR_COUNT_HIGH);
	assign value_low_sel  = (reg_addr_in == ccm_pkg::ADDR_VALUE_LOW);
	assign value_high_sel = (reg_addr_in == ccm_pkg::ADDR_VALUE_HIGH);

	// register write strobes; unmapped addresses hit no select and are ignored
	assign write_control    = reg_write_in & control_sel;
	assign write_mode       = reg_write_in & mode_sel;
	assign write_count_low  = reg_write_in & count_low_sel;
	assign write_count_high = reg_write_in & count_high_sel;
	assign write_value_low  = reg_write_in & value_low_sel;
	assign write_value_high = reg_write_in & value_high_sel;
	assign count_written    = write_count_low | write_count_high;

	// shared counter: a software write to either byte takes the place of that cycle's step
	assign counter_advance = counter_run_reg & ~count_written;
	assign low_byte_wrap   = counter_advance & (counter_reg[7:0] == ccm_pkg::LOW_BYTE_TOP);
	assign full_wrap       = counter_advance & (counter_reg == ccm_pkg::COUNT_TOP);

	assign counter_next = write_count_low  ? {counter_reg[15:8], reg_wdata_in} :
	                      write_count_high ? {reg_wdata_in, counter_reg[7:0]} :
	                      counter_advance  ? counter_reg + ccm_pkg::COUNT_STEP : counter_reg;
	assign advanced_next = counter_advance;

	// one compare per step, on the value the counter has just reached;
	// a software write that lands on the compare value is not a step and gives no match
	assign match_event = advanced_reg & comparator_enable & (counter_reg == value_reg);

	// capture trigger, only in a pure capture setting
	assign capture_event = capture_mode & ((rising_capture_enable & pin_edges.rise_pulse)
		| (falling_capture_enable & pin_edges.fall_pulse));

	// module value: capture wins over a software write in the same cycle;
	// the pwm reload copies value high into value low at each low byte wrap, so duty changes glitch free
	assign value_next = capture_event    ? counter_reg :
	                    (pwm_mode & low_byte_wrap) ? {value_reg[15:8], value_reg[15:8]} :
	                    write_value_low  ? {value_reg[15:8], reg_wdata_in} :
	                    write_value_high ? {reg_wdata_in, value_reg[7:0]} : value_reg;

	// flags: a hardware set wins over a software clear in the same cycle;
	// software may write either level, only the hardware set outranks it
	assign event_flag_next = capture_event | (match_event & match_flag_enable)
		| (write_control ? reg_wdata_in[ccm_pkg::BIT_MODULE_EVENT_FLAG] : event_flag_reg);
	assign overflow_flag_next = full_wrap
		| (write_control ? reg_wdata_in[ccm_pkg::BIT_COUNTER_OVERFLOW] : overflow_flag_reg);
	assign counter_run_next = write_control ? reg_wdata_in[ccm_pkg::BIT_COUNTER_RUN] : counter_run_reg;
	assign mode_next = write_mode ? (reg_wdata_in & ccm_pkg::MODE_IMPL_MASK) : mode_reg;

	// interrupt request follows the flag, gated by its enable
	assign irq_next = event_flag_reg & module_irq_enable;

	// pwm: low while counter low byte is under the duty byte, high at or above
	assign pwm_level = (counter_next[7:0] >= value_next[7:0]);

	// pin drive: pwm level, or toggle on each match; otherwise released for capture input,
	// so an outside driver owns the pin in every capture or idle setting
	assign drive_pin      = pwm_mode | (comparator_enable & match_toggle_enable);
	assign pin_oe_n_next  = ~drive_pin;
	assign pin_level_next = pwm_mode ? pwm_level :
	                        (match_event & match_toggle_enable) ? ~pin_level_reg : pin_level_reg;

	// read side; unmapped addresses and idle cycles return zero
	// read data is registered, so it stands only in the cycle after the strobe
	assign control_view = {overflow_flag_reg, counter_run_reg, 5'h00, event_flag_reg} & ccm_pkg::CONTROL_IMPL_MASK;
	assign read_value = control_sel    ? control_view :
	                    mode_sel       ? mode_reg :
	                    count_low_sel  ? counter_reg[7:0] :
	                    count_high_sel ? counter_reg[15:8] :
	                    value_low_sel  ? value_reg[7:0] :
	                    value_high_sel ? value_reg[15:8] : ccm_pkg::READ_IDLE;
	assign rdata_next = reg_read_in ? read_value : ccm_pkg::READ_IDLE;

	// software-owned bits: mode byte and counter run control
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			mode_reg        <= ccm_pkg::MODE_RESET;
			counter_run_reg <= 1'b0;
		end else begin
			mode_reg        <= mode_next;
			counter_run_reg <= counter_run_next;
		end
	end

	// shared counter and its step marker, which paces the compare
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			counter_reg  <= ccm_pkg::COUNT_RESET;
			advanced_reg <= 1'b0;
		end else begin
			counter_reg  <= counter_next;
			advanced_reg <= advanced_next;
		end
	end

	// module value bytes, loaded by software, capture or the pwm reload
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			value_reg <= ccm_pkg::VALUE_RESET;
		end else begin
			value_reg <= value_next;
		end
	end

	// status flags; set and clear priority is settled in the next-value logic
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			overflow_flag_reg <= 1'b0;
			event_flag_reg    <= 1'b0;
		end else begin
			overflow_flag_reg <= overflow_flag_next;
			event_flag_reg    <= event_flag_next;
		end
	end

	// pin output flops; pin released until a driving mode is chosen
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pin_level_reg <= ccm_pkg::PIN_RESET;
			pin_oe_n_reg  <= 1'b1;
		end else begin
			pin_level_reg <= pin_level_next;
			pin_oe_n_reg  <= pin_oe_n_next;
		end
	end

	// interrupt request flop, one cycle behind the flag
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= irq_next;
		end
	end

	// read data and function status flops
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rdata_reg    <= ccm_pkg::READ_IDLE;
			function_reg <= ccm_pkg::MODE_IDLE;
		end else begin
			rdata_reg    <= rdata_next;
			function_reg <= function_next;
		end
	end

	assign module_pin_out      = pin_level_reg;
	assign module_pin_oe_n_out = pin_oe_n_reg;
	assign module_irq_out      = irq_reg;
	assign reg_rdata_out       = rdata_reg;
	assign module_function_out = function_reg;

endmodule

//--- pin_partner.sv
// external load on the module pin
`timescale 1ns/1ps
module pin_partner (
	// levels
	input  wire logic level_in,
	input  wire logic pin_drive_in,
	input  wire logic oe_n_in,
	// resolved line
	output logic      line_out
);
	// the load gives way while the module drives, so the line never sees contention
	assign line_out = oe_n_in ? level_in : pin_drive_in;
endmodule

//--- ccm_props.sv
// port assertions for the compare/capture module
`timescale 1ns/1ps
module ccm_props (
	// clock and reset
	input wire logic       mclk_in,
	input wire logic       rst_n_in,
	// register port
	input wire logic [2:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic       reg_write_in,
	input wire logic       reg_read_in,
	input wire logic [7:0] reg_rdata_out,
	// pin and status
	input wire logic       module_pin_out,
	input wire logic       module_pin_oe_n_out,
	input wire logic       module_irq_out,
	input wire logic [2:0] module_function_out
);
	logic [7:0] mode_reg;
	logic       run_reg;
	logic [2:0] cmp_hist_reg;

	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (!rst_n_in);

	// shadows of software bits; hardware never alters them
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			mode_reg <= 8'h00;
			run_reg <= 1'b0;
			cmp_hist_reg <= 3'h0;
		end else begin
			cmp_hist_reg <= {cmp_hist_reg[1:0], mode_reg[6]};
			if (reg_write_in && reg_addr_in == 3'h1) begin
				mode_reg <= reg_wdata_in;
			end
			if (reg_write_in && reg_addr_in == 3'h0) begin
				run_reg <= reg_wdata_in[6];
			end
		end
	end

	// expected function code of a mode byte; bit 7 is ignored
	function automatic logic [2:0] fn_of(input logic [7:0] m);
		if (m[6:0] == 7'h00) return 3'h0;
		if (m[3:1] == 3'h0 && m[5:4] != 2'h0) return 3'h1;
		if (m[6:1] == 6'h24) return 3'h2;
		if (m[6:1] == 6'h26) return 3'h3;
		if (m[6:0] == 7'h42) return 3'h4;
		return 3'h5;
	endfunction

	a_function_decode: assert property (reg_write_in && reg_addr_in == 3'h1 |-> ##2
		module_function_out == fn_of($past(reg_wdata_in, 2))) else $error("function code wrong");
	a_mode_readback: assert property (reg_write_in && reg_addr_in == 3'h1 ##1 reg_read_in && reg_addr_in == 3'h1
		|=> reg_rdata_out == ($past(reg_wdata_in, 2) & 8'h7f)) else $error("mode read-back wrong");
	a_irq_needs_enable: assert property (!$past(mode_reg[0]) |-> !module_irq_out) else $error("irq while masked");
	a_drive_needs_compare: assert property ($fell(module_pin_oe_n_out) |-> $past(mode_reg[6]))
		else $error("pin driven without comparator");
	a_pin_moves_compare: assert property ($changed(module_pin_out) |-> |{cmp_hist_reg, mode_reg[6]})
		else $error("pin moved without comparator");
	a_status_reserved_zero: assert property (reg_read_in && reg_addr_in == 3'h0 |=> reg_rdata_out[5:1] == 5'h00)
		else $error("reserved status bits set");
	a_counter_held: assert property (!run_reg && reg_read_in && reg_addr_in == 3'h2 ##1
		reg_read_in && reg_addr_in == 3'h2 |=> reg_rdata_out == $past(reg_rdata_out)) else $error("counter moved");
	a_value_readback: assert property (module_function_out == 3'h2 && reg_write_in && reg_addr_in == 3'h4 ##1
		reg_read_in && reg_addr_in == 3'h4 |=> reg_rdata_out == $past(reg_wdata_in, 2)) else $error("value read-back");

	c_irq_raised: cover property ($rose(module_irq_out));
	c_pin_driven: cover property ($fell(module_pin_oe_n_out));
	c_capture_mode: cover property (module_function_out == 3'h1);
endmodule

bind compare_capture_module ccm_props ccm_props_inst (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
	.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in),
	.reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out), .module_pin_out(module_pin_out),
	.module_pin_oe_n_out(module_pin_oe_n_out), .module_irq_out(module_irq_out),
	.module_function_out(module_function_out));

//--- testbench.sv
// self-checking bench for the compare/capture module
`timescale 1ns/1ps
module testbench;
	typedef struct {logic [7:0] mode; logic [2:0] fn;} row_type;
	logic       mclk_in;
	logic       rst_n_in;
	logic [2:0] addr;
	logic [7:0] wdata;
	logic       wr;
	logic       rd;
	logic [7:0] rdata;
	logic       pin_out;
	logic       oe_n;
	logic       irq;
	logic [2:0] func;
	logic       level;
	logic       line;
	logic       p0;
	logic [7:0] got;
	int         bad_count = 0;
	int         comparisons = 0;
	int         cycles = 0;
	int         n;
	row_type    rows [10] = '{'{8'h00, 3'h0}, '{8'h20, 3'h1}, '{8'h10, 3'h1}, '{8'h70, 3'h1}, '{8'h48, 3'h2},
		'{8'hc9, 3'h2}, '{8'h4c, 3'h3}, '{8'h42, 3'h4}, '{8'h43, 3'h5}, '{8'h01, 3'h5}};
	logic [7:0] caps [3] = '{8'h20, 8'h10, 8'h30};

	compare_capture_module compare_capture_module_inst (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .reg_addr_in(addr),
		.reg_wdata_in(wdata), .reg_write_in(wr), .reg_read_in(rd), .reg_rdata_out(rdata), .module_pin_in(line),
		.module_pin_out(pin_out), .module_pin_oe_n_out(oe_n), .module_irq_out(irq), .module_function_out(func));
	pin_partner pin_partner_inst (.level_in(level), .pin_drive_in(pin_out), .oe_n_in(oe_n), .line_out(line));

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic complete_run();
		$display("comparisons=%0d mismatches=%0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// one bus cycle, launched just after a rising edge
	task automatic bus(input logic w, input logic r, input logic [2:0] a, input logic [7:0] d);
		@(posedge mclk_in);
		wr <= w;
		rd <= r;
		addr <= a;
		wdata <= d;
	endtask

	task automatic idle(input int k);
		repeat (k) @(posedge mclk_in);
	endtask

	task automatic wrt(input logic [2:0] a, input logic [7:0] d);
		bus(1'b1, 1'b0, a, d);
		bus(1'b0, 1'b0, 3'h0, 8'h00);
	endtask

	// read data is valid only in the cycle after the strobe
	task automatic rdt(input logic [2:0] a);
		bus(1'b0, 1'b1, a, 8'h00);
		bus(1'b0, 1'b0, 3'h0, 8'h00);
		#1;
		got = rdata;
	endtask

	initial begin
		mclk_in = 1'b0;
		forever #2 mclk_in = ~mclk_in;
	end

	// hang guard, well above the roughly seven hundred cycles the run needs
	always @(posedge mclk_in) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			bad_count++;
			complete_run();
		end
	end

	initial begin
		rst_n_in = 1'b0;
		addr = 3'h0;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
		level = 1'b1;
		idle(5);
		rst_n_in <= 1'b1;
		#1;
		check({pin_out, oe_n, irq, func, 2'h0}, 8'hc0);
		wrt(3'h7, 8'hff);
		for (int a = 0; a < 8; a++) begin
			rdt(3'(a));
			check(got, 8'h00);
		end
		foreach (rows[i]) begin
			bus(1'b1, 1'b0, 3'h1, rows[i].mode);
			rdt(3'h1);
			check(got, rows[i].mode & 8'h7f);
			check({5'h00, func}, {5'h00, rows[i].fn});
		end
		$display("done: reset, map, modes");
		// eleven increments between run taken and stop taken
		wrt(3'h0, 8'h40);
		idle(9);
		wrt(3'h0, 8'h00);
		bus(1'b0, 1'b1, 3'h2, 8'h00);
		rdt(3'h2);
		check(got, 8'h0b);
		wrt(3'h2, 8'h00);
		wrt(3'h1, 8'h49);
		idle(2);
		bus(1'b1, 1'b0, 3'h4, 8'h10);
		rdt(3'h4);
		check(got, 8'h10);
		wrt(3'h5, 8'h01);
		wrt(3'h0, 8'h40);
		idle(260);
		check({7'h00, irq}, 8'h00);
		n = 0;
		while (irq !== 1'b1 && n < 20) begin
			idle(1);
			n++;
		end
		check({7'h00, irq}, 8'h01);
		rdt(3'h0);
		check(got, 8'h41);
		wrt(3'h0, 8'h00);
		idle(2);
		check({7'h00, irq}, 8'h00);
		wrt(3'h1, 8'h48);
		wrt(3'h0, 8'h01);
		idle(3);
		check({7'h00, irq}, 8'h00);
		wrt(3'h1, 8'h49);
		idle(3);
		check({7'h00, irq}, 8'h01);
		$display("done: counter and timer");
		for (int a = 2; a < 6; a++) begin
			wrt(3'(a), (a == 4) ? 8'h05 : 8'h00);
		end
		wrt(3'h1, 8'h4c);
		idle(3);
		p0 = pin_out;
		check({7'h00, oe_n}, 8'h00);
		wrt(3'h0, 8'h40);
		idle(20);
		wrt(3'h0, 8'h00);
		check({7'h00, pin_out}, {7'h00, ~p0});
		wrt(3'h1, 8'h42);
		wrt(3'h4, 8'h80);
		for (int k = 0; k < 2; k++) begin
			wrt(3'h2, 8'h7f + 8'(k));
			idle(3);
			check({6'h00, oe_n, pin_out}, {7'h00, 1'(k)});
		end
		// value byte bits 7..5 tell which pin edge was captured
		foreach (caps[i]) begin
			wrt(3'h1, caps[i]);
			for (int a = 2; a < 6; a++) begin
				wrt(3'(a), 8'h00);
			end
			wrt(3'h0, 8'h40);
			idle(32);
			level <= 1'b0;
			idle(30);
			rdt(3'h4);
			check({5'h00, got[7:5]}, {7'h00, caps[i][4]});
			@(posedge mclk_in);
			level <= 1'b1;
			idle(10);
			wrt(3'h0, 8'h00);
			rdt(3'h4);
			check({5'h00, got[7:5]}, caps[i][5] ? 8'h02 : {7'h00, caps[i][4]});
		end
		$display("done: toggle, pwm, capture");
		// a full count wrap sets the overflow flag, then a reset in mid-run must release the pin and clear the irq, function and status outputs
		wrt(3'h2, 8'hff);
		wrt(3'h3, 8'hff);
		wrt(3'h0, 8'h40);
		rdt(3'h0);
		check(got, 8'hc0);
		@(posedge mclk_in);
		rst_n_in <= 1'b0;
		idle(2);
		rst_n_in <= 1'b1;
		#1;
		check({pin_out, oe_n, irq, func, 2'h0}, 8'hc0);
		rdt(3'h0);
		check(got, 8'h00);
		$display("done: overflow, mid-run reset");
		complete_run();
	end
endmodule
